// *** sim/biw_rc_model.sv ***
// Root complex side issuing configuration accesses
`timescale 1ns/1ps
module biw_rc_model (
   input wire logic             clock,
   output biw_pkg::biw_cfg_req_s req
);
   initial req = '0;
   // One-cycle request, as the bank takes it on a single edge
   task access(input logic w, input logic [7:0] a, input logic [3:0] be,
               input logic [31:0] d);
      @(negedge clock);
      req <= '{1'b1, w, a, be, d};
      @(negedge clock);
      req.valid <= 1'b0;
   endtask : access
endmodule : biw_rc_model

// *** sim/biw_window_bank_assertions.sv ***
// Port-level checks of the window bank
`timescale 1ns/1ps
module biw_window_bank_assertions #(
   parameter bit AER_PRESENT = 1'b0
) (
   input wire logic                  clock,
   input wire logic                  rst_b,
   input wire biw_pkg::biw_cfg_req_s cfg_req,
   input wire logic                  cfg_ack,
   input wire logic [31:0]           cfg_rdata,
   input wire logic                  io_req_valid,
   input wire logic                  io_forward,
   input wire logic                  completion_at_head,
   input wire logic                  drop_delayed,
   input wire biw_pkg::biw_err_msg_s err_msg
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   ack_follows_req_a: assert property (cfg_req.valid |=> cfg_ack)
      else $error("no ack after request");
   ack_needs_req_a: assert property (!cfg_req.valid |=> !cfg_ack)
      else $error("ack without request");
   cap_head_val_a: assert property (cfg_req.valid && !cfg_req.write
      && cfg_req.addr == 8'h34 |=> cfg_rdata == 32'h00000080)
      else $error("capability head wrong");
   write_data_zero_a: assert property (cfg_req.valid && cfg_req.write
      |=> cfg_rdata == 32'h00000000) else $error("write returned data");
   unmapped_zero_a: assert property (cfg_req.valid && !(cfg_req.addr
      inside {8'h30, 8'h34, 8'h3C}) |=> cfg_rdata == 32'h00000000)
      else $error("unmapped read not zero");
   fwd_needs_req_a: assert property (!io_req_valid |=> !io_forward)
      else $error("forward without request");
   msg_after_drop_a: assert property (err_msg.msg_valid
      |-> $past(drop_delayed)) else $error("message without drop");
   fatal_default_a: assert property (!AER_PRESENT |-> !err_msg.fatal)
      else $error("fatal without advanced reporting");
   drop_one_pulse_a: assert property (drop_delayed |=> !drop_delayed)
      else $error("drop longer than a cycle");
   drop_needs_head_a: assert property (drop_delayed
      |-> $past(completion_at_head, 2)) else $error("drop without head");
endmodule : biw_window_bank_assertions

// *** sim/bridge_io_window_discard_cfg_tb_top.sv ***
// Self-checking bench of the window bank
`timescale 1ns/1ps
module bridge_io_window_discard_cfg_tb_top;
   logic clock = 0, rst_b = 0, io_req_valid = 0, pci_mode = 0, head = 0;
   logic master_repeat = 0, io_fwd_d1 = 0;
   logic [15:0] base_lo = 16'h1000, lim_lo = 16'h2FFF;
   logic [31:0] io_req_addr = '0, rdata, seed = 32'hbe1164e8, up, base, lim;
   logic [31:0] cq[$];
   logic iq[$];
   logic cfg_ack, io_forward, drop_delayed, sel_out;
   int failures = 0, n_compared = 0, n_msg = 0, n;
   biw_pkg::biw_cfg_req_s cfg_req;
   biw_pkg::biw_err_msg_s err_msg;
   biw_rc_model biw_rc_model_i (.clock(clock), .req(cfg_req));
   biw_window_bank biw_window_bank_i (.clock(clock), .rst_b(rst_b),
      .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(rdata),
      .io_base_lower(base_lo), .io_limit_lower(lim_lo),
      .io_req_valid(io_req_valid), .io_req_addr(io_req_addr),
      .io_forward(io_forward), .pci_mode(pci_mode), .aer_fatal_sel(1'b0),
      .aer_expiry_mask(1'b0), .completion_at_head(head),
      .master_repeat(master_repeat), .drop_delayed(drop_delayed),
      .err_msg(err_msg), .secondary_expiry_select(sel_out));
   initial forever #2 clock = ~clock;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task rd(input logic [7:0] a, input logic [31:0] e);
      cq.push_back(e);
      biw_rc_model_i.access(1'b0, a, 4'hF, 32'h0);
   endtask : rd
   task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      cq.push_back(32'h0);
      biw_rc_model_i.access(1'b1, a, be, d);
   endtask : wr
   task io(input logic [31:0] a, input logic e);
      iq.push_back(e);
      @(negedge clock);
      io_req_valid <= 1'b1;
      io_req_addr  <= a;
      @(negedge clock);
      io_req_valid <= 1'b0;
   endtask : io
   task stop_test;
      if (failures == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   // Outputs settle after the edge, so results are taken at the falling one
   always @(posedge clock) begin
      io_fwd_d1 <= io_req_valid;
      if (err_msg.msg_valid === 1'b1) n_msg++;
   end
   always @(negedge clock) begin
      if (cfg_ack === 1'b1) chk("cfg_rdata", cq.pop_front(), rdata);
      if (io_fwd_d1) chk("io_forward", iq.pop_front(), io_forward);
   end
   initial begin
      #(4 * 60000);
      failures++;
      stop_test;
   end
   initial begin
      repeat (3) @(negedge clock);
      rst_b = 1;
      rd(8'h30, 32'h0);
      rd(8'h34, 32'h80);
      rd(8'h3C, 32'hFF);
      wr(8'h34, 4'hF, 32'hFFFFFFFF);
      rd(8'h34, 32'h80);
      rd(8'h40, 32'h0);
      for (int k = 0; k < 4; k++) begin
         seed = xs(seed);
         up = {seed[15:0] + 16'h1, seed[15:0]};
         base = {up[15:0], base_lo};
         lim = {up[31:16], lim_lo};
         wr(8'h30, 4'hF, up);
         rd(8'h30, up);
         io(base - 1, 1'b0);
         io(base, 1'b1);
         io(lim, 1'b1);
         io(lim + 1, 1'b0);
      end
      for (int i = 0; i < 3; i++) begin
         pci_mode <= (i != 2);
         wr(8'h3C, 4'b1000, {4'h0, 1'b1, 1'b0, i != 1, 25'h0});
         n_msg = 0;
         n = 0;
         @(negedge clock) head <= 1'b1;
         while (drop_delayed !== 1'b1 && n < 40000) @(negedge clock) n++;
         chk("expiry", 1, n >= ((i != 1) ? 1020 : 32764) &&
             n <= ((i != 1) ? 1030 : 32774));
         head <= 1'b0;
         repeat (3) @(negedge clock);
         chk("msg", (i != 2), n_msg);
         chk("sel", (i != 1), sel_out);
         rd(8'h3C, {4'h0, 1'b1, 1'b1, i != 1, 17'h0, 8'hFF});
      end
      wr(8'h3C, 4'b1000, 32'h0A000000);
      rd(8'h3C, 32'h0E0000FF);
      wr(8'h3C, 4'b1000, 32'h06000000);
      rd(8'h3C, 32'h020000FF);
      @(negedge clock) head <= 1'b1;
      repeat (100) @(negedge clock);
      master_repeat <= 1'b1;
      head          <= 1'b0;
      @(negedge clock) master_repeat <= 1'b0;
      n = 0;
      while (drop_delayed !== 1'b1 && n < 1200) @(negedge clock) n++;
      chk("cancel", 1200, n);
      head <= 1'b0;
      repeat (4) @(negedge clock);
      stop_test;
   end
endmodule : bridge_io_window_discard_cfg_tb_top
bind biw_window_bank biw_window_bank_assertions #(.AER_PRESENT(AER_PRESENT))
   biw_window_bank_assertions_i (.clock(clock), .rst_b(rst_b),
   .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
   .io_req_valid(io_req_valid), .io_forward(io_forward),
   .completion_at_head(completion_at_head), .drop_delayed(drop_delayed),
   .err_msg(err_msg));

// *** src/biw_defines.svh ***
// Offsets, field positions, reset values and timing counts for the window bank
`ifndef BIW_DEFINES_SVH
`define BIW_DEFINES_SVH
`define BIW_OFF_IO_UPPER     8'h30
`define BIW_OFF_CAP_HEAD     8'h34
`define BIW_OFF_BRIDGE_CTL   8'h3C
`define BIW_CAP_HEAD_VAL     8'h80
`define BIW_RST_IO_UPPER     32'h00000000
`define BIW_RST_IRQ_LINE     8'hFF
`define BIW_BIT_ERR_EN       27
`define BIW_BIT_DISC_STAT    26
`define BIW_BIT_EXP_SEL      25
`define BIW_EXP_LONG_LOG2    15
`define BIW_EXP_SHORT_LOG2   10
`define BIW_EXP_CNT_W        16
`endif

// *** src/biw_discard_timer.sv ***
// Secondary discard timer for one delayed completion
`timescale 1ns/1ps
`include "biw_defines.svh"
module biw_discard_timer (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic short_sel,
   input  wire logic head_reached,
   input  wire logic repeat_seen,
   output logic      expired
);
   biw_pkg::biw_timer_e                 st_ff, nxt_st;
   logic [`BIW_EXP_CNT_W-1:0]           cnt_ff, nxt_cnt;
   logic [`BIW_EXP_CNT_W-1:0]           limit;
   logic                                exp_ff, nxt_exp;

   // R11
   assign limit = short_sel ?
      `BIW_EXP_CNT_W'(1 << `BIW_EXP_SHORT_LOG2) - 1'b1 :
      `BIW_EXP_CNT_W'(1 << `BIW_EXP_LONG_LOG2) - 1'b1;
   assign expired = exp_ff;

   always_comb begin
      nxt_st  = st_ff;
      nxt_cnt = cnt_ff;
      nxt_exp = 1'b0;
      case (st_ff)
         biw_pkg::BIW_T_IDLE: begin
            nxt_cnt = '0;
            if (head_reached) begin
               nxt_st = biw_pkg::BIW_T_RUN; // R11
            end
         end
         biw_pkg::BIW_T_RUN: begin
            if (repeat_seen) begin
               nxt_st = biw_pkg::BIW_T_IDLE;
            end else if (cnt_ff >= limit) begin
               nxt_exp = 1'b1; // R12
               nxt_st  = biw_pkg::BIW_T_DONE;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         biw_pkg::BIW_T_DONE: begin
            // Entry is dropped; wait for the queue to drop head
            if (!head_reached) begin
               nxt_st = biw_pkg::BIW_T_IDLE;
            end
         end
         default: nxt_st = biw_pkg::BIW_T_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_ff  <= biw_pkg::BIW_T_IDLE;
         cnt_ff <= '0;
         exp_ff <= 1'b0;
      end else begin
         st_ff  <= nxt_st;
         cnt_ff <= nxt_cnt;
         exp_ff <= nxt_exp;
      end
   end
endmodule : biw_discard_timer

// *** src/biw_pkg.sv ***
// Types shared by the window bank
package biw_pkg;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } biw_cfg_req_s;
   typedef struct packed {
      logic        msg_valid;
      logic        fatal;
   } biw_err_msg_s;
   typedef enum logic [1:0] {
      BIW_T_IDLE,
      BIW_T_RUN,
      BIW_T_DONE
   } biw_timer_e;
endpackage : biw_pkg

// *** src/biw_window_bank.sv ***
// Config bank: I/O window upper halves, capability head, bridge control top
// Behaviour
// R1: Bits 31:16 of the I/O upper register are limit address bits 31:16.
// R2: Bits 15:0 of the I/O upper register are base address bits 31:16.
// R3: The 32-bit base and limit decide forwarding; both halves RW, reset 0.
// R4: Address inside when >= base and <= limit with limit low bits all ones; the bank takes the limit low 16 bits from io_limit_lower as given.
// R5: Capability head reads fixed 0x80 in bits 7:0, upper bits zero.
// R6: With bit 27 set, a discard expiry sends an error message, non-fatal.
// R7: Fatal severity is selectable only when advanced reporting exists.
// R8: With bit 27 clear, only the advanced reporting path may report it.
// R9: Bit 27 acts only in PCI mode, is RW and resets to zero.
// R10: Bit 26 sets on discard expiry, clears on write 1, write 0 keeps it.
// R11: Timer counts 2^15 clocks, or 2^10 when selected, from queue head.
// R12: No repeat before expiry drops the transaction and sets the status.
`timescale 1ns/1ps
`include "biw_defines.svh"
module biw_window_bank #(
   parameter bit AER_PRESENT = 1'b0
) (
   input  wire logic                 clock,
   input  wire logic                 rst_b,
   input  wire biw_pkg::biw_cfg_req_s cfg_req,
   output logic                      cfg_ack,
   output logic [31:0]               cfg_rdata,
   input  wire logic [15:0]          io_base_lower,
   input  wire logic [15:0]          io_limit_lower,
   input  wire logic                 io_req_valid,
   input  wire logic [31:0]          io_req_addr,
   output logic                      io_forward,
   input  wire logic                 pci_mode,
   input  wire logic                 aer_fatal_sel,
   input  wire logic                 aer_expiry_mask,
   input  wire logic                 completion_at_head,
   input  wire logic                 master_repeat,
   output logic                      drop_delayed,
   output biw_pkg::biw_err_msg_s     err_msg,
   output logic                      secondary_expiry_select
);
   logic [15:0] io_limit_upper_ff, nxt_io_limit_upper;
   logic [15:0] io_base_upper_ff, nxt_io_base_upper;
   logic        expiry_error_enable_ff, nxt_expiry_error_enable;
   logic        disc_stat_ff, nxt_disc_stat;
   logic        exp_sel_ff, nxt_exp_sel;
   logic [7:0]  irq_line_ff, nxt_irq_line;
   logic        ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        fwd_ff, nxt_fwd;
   biw_pkg::biw_err_msg_s msg_ff, nxt_msg;
   logic        expired;
   logic [31:0] base32, limit32;
   logic        wr_io, wr_ctl;

   // Byte-lane write merge, used by every writable field except the write-1-clear bit 26
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   biw_discard_timer u_timer (
      .clock        (clock),
      .rst_b        (rst_b),
      .short_sel    (exp_sel_ff),
      .head_reached (completion_at_head),
      .repeat_seen  (master_repeat),
      .expired      (expired)
   );

   assign wr_io  = cfg_req.valid && cfg_req.write &&
                   cfg_req.addr == `BIW_OFF_IO_UPPER;
   assign wr_ctl = cfg_req.valid && cfg_req.write &&
                   cfg_req.addr == `BIW_OFF_BRIDGE_CTL;

   // Low 16 bits come straight from the io_base_lower and io_limit_lower inputs
   assign base32  = {io_base_upper_ff, io_base_lower}; // R2
   assign limit32 = {io_limit_upper_ff, io_limit_lower}; // R1

   always_comb begin
      logic [31:0] io_word;
      logic [31:0] ctl_word;
      io_word  = {io_limit_upper_ff, io_base_upper_ff};
      ctl_word = {4'h0, expiry_error_enable_ff, disc_stat_ff, exp_sel_ff,
                  17'h00000, irq_line_ff};
      nxt_io_limit_upper      = io_limit_upper_ff;
      nxt_io_base_upper       = io_base_upper_ff;
      nxt_expiry_error_enable = expiry_error_enable_ff;
      nxt_exp_sel             = exp_sel_ff;
      nxt_irq_line            = irq_line_ff;
      nxt_disc_stat           = disc_stat_ff;
      if (wr_io) begin
         io_word = lane_merge(io_word, cfg_req.wdata, cfg_req.be); // R3
         nxt_io_limit_upper = io_word[31:16]; // R1
         nxt_io_base_upper  = io_word[15:0]; // R2
      end
      if (wr_ctl) begin
         ctl_word = lane_merge(ctl_word, cfg_req.wdata, cfg_req.be);
         nxt_expiry_error_enable = ctl_word[`BIW_BIT_ERR_EN]; // R9
         nxt_exp_sel             = ctl_word[`BIW_BIT_EXP_SEL];
         nxt_irq_line            = ctl_word[7:0];
         if (cfg_req.be[3] && cfg_req.wdata[`BIW_BIT_DISC_STAT]) begin
            nxt_disc_stat = 1'b0; // R10
         end
      end
      // Set beats a same-cycle clear
      if (expired) begin
         nxt_disc_stat = 1'b1; // R10 R12
      end
   end

   always_comb begin
      nxt_ack   = cfg_req.valid;
      nxt_rdata = 32'h00000000;
      if (cfg_req.valid && !cfg_req.write) begin
         case (cfg_req.addr)
            `BIW_OFF_IO_UPPER:
               nxt_rdata = {io_limit_upper_ff, io_base_upper_ff};
            `BIW_OFF_CAP_HEAD:
               nxt_rdata = {24'h000000, `BIW_CAP_HEAD_VAL}; // R5
            `BIW_OFF_BRIDGE_CTL:
               nxt_rdata = {4'h0, expiry_error_enable_ff, disc_stat_ff,
                            exp_sel_ff, 17'h00000, irq_line_ff};
            default: nxt_rdata = 32'h00000000;
         endcase
      end
   end

   always_comb begin
      nxt_fwd = io_req_valid && io_req_addr >= base32 &&
                io_req_addr <= limit32; // R4 R3
      nxt_msg = '0;
      if (expired && pci_mode && expiry_error_enable_ff) begin
         nxt_msg.msg_valid = 1'b1; // R6 R9
      end else if (expired && AER_PRESENT && !aer_expiry_mask) begin
         nxt_msg.msg_valid = 1'b1; // R8
      end
      // Fatal only selectable with advanced reporting
      nxt_msg.fatal = nxt_msg.msg_valid && AER_PRESENT && aer_fatal_sel; // R7
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         io_limit_upper_ff      <= 16'h0000;
         io_base_upper_ff       <= 16'h0000;
         expiry_error_enable_ff <= 1'b0;
         disc_stat_ff           <= 1'b0;
         exp_sel_ff             <= 1'b0;
         irq_line_ff            <= `BIW_RST_IRQ_LINE;
         ack_ff                 <= 1'b0;
         rdata_ff               <= 32'h00000000;
         fwd_ff                 <= 1'b0;
         msg_ff                 <= '0;
      end else begin
         io_limit_upper_ff      <= nxt_io_limit_upper;
         io_base_upper_ff       <= nxt_io_base_upper;
         expiry_error_enable_ff <= nxt_expiry_error_enable;
         disc_stat_ff           <= nxt_disc_stat;
         exp_sel_ff             <= nxt_exp_sel;
         irq_line_ff            <= nxt_irq_line;
         ack_ff                 <= nxt_ack;
         rdata_ff               <= nxt_rdata;
         fwd_ff                 <= nxt_fwd;
         msg_ff                 <= nxt_msg;
      end
   end

   assign cfg_ack                 = ack_ff;
   assign cfg_rdata               = rdata_ff;
   assign io_forward              = fwd_ff;
   assign err_msg                 = msg_ff;
   assign drop_delayed            = expired; // R12
   assign secondary_expiry_select = exp_sel_ff;
endmodule : biw_window_bank
